// >>> verilog/wdg_mode_guard.sv
// file: watchdog mode register guard, restart key and internal reset
// ========================================
`timescale 1ns/1ps
`default_nettype none
module wdg_mode_guard
    import wdg_pkg::*;
(
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               reset,
    // option strap: 1 = oscillator cannot be stopped
    input  wire logic               osc_fixed_opt,
    // cpu access to mode register
    input  wire logic               mode_wr,
    input  wire logic               mode_bit_op,
    input  wire logic [7:0]         mode_wdata,
    output var  logic [7:0]         mode_rdata,
    output logic                    bus_wait,
    // cpu access to restart key register
    input  wire logic               key_wr,
    input  wire logic [7:0]         key_wdata,
    output var  logic [7:0]         key_rdata,
    // clock and power state
    input  wire logic               src_clk_run,
    input  wire logic               cpu_halt,
    input  wire logic               cpu_stop,
    // status
    output var  logic               wdg_running,
    output var  logic [CNT_W-1:0]   wdg_count,
    output var  logic               internal_reset
);
    // ========================================
    // mode register, write-once
    logic [7:0]  mode_reg;
    logic        written_reg;
    logic        stopped_reg;
    logic        pend_reg;
    logic [2:0]  pulse_reg;
    logic        wait_busy_reg;
    wdg_wait_t   wait_state_reg;
    logic        byte_wr;
    logic        mode_start;
    logic        rst_cause;
    logic        illegal_mode;
    logic        bad_key;
    logic        ovf;
    logic        count_en;
    logic        restart;
    logic [7:0]  mode_next;

    // restart key decode, shared by the clear and reset paths
    function automatic logic is_restart_key(input logic [7:0] v);
        is_restart_key = (v == KEY_RESTART);
    endfunction : is_restart_key

    // the strobe stands through the wait, so only its first cycle counts
    assign mode_start   = mode_wr && (wait_state_reg == WDG_IDLE);
    // bit ops never reach the register
    assign byte_wr      = mode_start && !mode_bit_op;
    assign illegal_mode = mode_start && written_reg;
    assign bad_key      = key_wr && !is_restart_key(key_wdata);
    assign restart      = key_wr && is_restart_key(key_wdata);
    assign rst_cause    = illegal_mode || bad_key || ovf;

    always_comb begin
        mode_next = mode_wdata;
        // fixed option forces the mandatory top pattern
        if (osc_fixed_opt) begin
            mode_next[MODE_FIXED_HI:MODE_FIXED_LO] = MODE_FIXED_PAT;
            mode_next[STOP_SEL_BIT] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode_reg <= MODE_RESET;
        end else if (byte_wr && !written_reg) begin
            mode_reg <= mode_next;
        end
    end

    // write-once lock, cleared only by system reset
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            written_reg <= 1'b0;
        end else if (byte_wr) begin
            written_reg <= 1'b1;
        end
    end

    // ========================================
    // stop select latches, clearing it later does not restart
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stopped_reg <= 1'b0;
        end else if (!osc_fixed_opt && mode_reg[STOP_SEL_BIT]) begin
            stopped_reg <= 1'b1;
        end
    end

    // ========================================
    // wait cycle on every mode write
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wait_state_reg <= WDG_IDLE;
            wait_busy_reg  <= 1'b0;
        end else begin
            case (wait_state_reg)
                WDG_IDLE: begin
                    if (mode_wr) begin
                        wait_state_reg <= WDG_WAIT;
                        wait_busy_reg  <= 1'b1;
                    end
                end
                WDG_WAIT: begin
                    wait_state_reg <= WDG_DONE;
                    wait_busy_reg  <= 1'b0;
                end
                WDG_DONE: begin
                    wait_state_reg <= WDG_IDLE;
                    wait_busy_reg  <= 1'b0;
                end
                default: begin
                    wait_state_reg <= WDG_IDLE;
                    wait_busy_reg  <= 1'b0;
                end
            endcase
        end
    end
    // combinational so the first cycle of the access is held too
    assign bus_wait = (mode_wr && wait_state_reg == WDG_IDLE)
                    || wait_busy_reg;

    // ========================================
    // counter: fixed option ignores halt/stop; soft option pauses
    assign count_en = src_clk_run && !stopped_reg
        && (osc_fixed_opt
            || !(cpu_halt || cpu_stop));

    wdg_counter u_counter (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .count_en (count_en),
        .clear    (restart),
        .clk_sel  (mode_reg[CLK_SEL_HI:CLK_SEL_LO]),
        .overflow (ovf),
        .count    (wdg_count)
    );

    // ========================================
    // reset request, deferred while source clock stands
    // trade-off: pending request survives until a clock is seen
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pend_reg <= 1'b0;
        end else if (rst_cause) begin
            pend_reg <= 1'b1;
        end else if (src_clk_run) begin
            pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pulse_reg <= '0;
        end else if (pend_reg && src_clk_run) begin
            pulse_reg <= 3'(RST_PULSE_CYC);
        end else if (pulse_reg != '0) begin
            pulse_reg <= pulse_reg - 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            internal_reset <= 1'b0;
        end else begin
            internal_reset <= (pend_reg && src_clk_run)
                           || (pulse_reg > 3'h1);
        end
    end

    // ========================================
    // read data from flip-flops
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode_rdata <= MODE_RESET;
        end else begin
            mode_rdata <= mode_reg;
        end
    end

    // key reads never echo the key, so a fixed byte suffices
    always_ff @(posedge ref_clk) begin
        key_rdata <= KEY_READBACK;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wdg_running <= 1'b0;
        end else begin
            wdg_running <= count_en;
        end
    end
endmodule : wdg_mode_guard
`default_nettype wire

// >>> shared/wdg_pkg.sv
// package: watchdog mode guard constants and types
package wdg_pkg;
    // ========================================
    // register layout
    localparam int          MODE_W          = 8;
    localparam logic [7:0]  MODE_RESET      = 8'h67;
    localparam logic [2:0]  MODE_FIXED_PAT  = 3'h3;   // bits 7..5 = 0,1,1
    localparam int          MODE_FIXED_HI   = 7;
    localparam int          MODE_FIXED_LO   = 5;
    localparam int          STOP_SEL_BIT    = 4;
    localparam int          CLK_SEL_HI      = 2;
    localparam int          CLK_SEL_LO      = 0;
    localparam logic [7:0]  KEY_RESTART     = 8'hac;
    localparam logic [7:0]  KEY_READBACK    = 8'h9a;
    // ========================================
    // timing
    localparam int          CNT_W           = 20;
    localparam int          WAIT_CYCLES     = 1;
    localparam int          RST_PULSE_CYC   = 4;
    // ========================================
    // types
    typedef enum logic [1:0] {
        WDG_IDLE    = 2'b00,
        WDG_WAIT    = 2'b01,
        WDG_DONE    = 2'b10
    } wdg_wait_t;
endpackage : wdg_pkg

// >>> verilog/wdg_counter.sv
// file: watchdog counter on the source-clock tick
`timescale 1ns/1ps
`default_nettype none
module wdg_counter
    import wdg_pkg::*;
(
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               reset,
    // control
    input  wire logic               count_en,
    input  wire logic               clear,
    input  wire logic [2:0]         clk_sel,
    // status
    output var  logic               overflow,
    output var  logic [CNT_W-1:0]   count
);
    // ========================================
    // overflow point chosen by clock select
    function automatic logic [CNT_W-1:0] limit_of(input logic [2:0] sel);
        limit_of = CNT_W'((32'd1 << (32'(sel) + 32'd10)) - 32'd1);
    endfunction : limit_of

    logic [CNT_W-1:0] count_reg;

    // count is kept while paused, never cleared by a pause
    always_ff @(posedge ref_clk) begin
        if (reset || clear) begin
            count_reg <= '0;
        end else if (count_en) begin
            if (count_reg >= limit_of(clk_sel)) begin
                count_reg <= '0;
            end else begin
                count_reg <= count_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || clear) begin
            overflow <= 1'b0;
        end else begin
            overflow <= count_en && (count_reg >= limit_of(clk_sel));
        end
    end

    assign count = count_reg;
endmodule : wdg_counter
`default_nettype wire

// >>> test/wdg_guard_checker.sv
// checker: port assertions for the watchdog mode guard
`timescale 1ns/1ps
`default_nettype none
module wdg_guard_checker
    import wdg_pkg::*;
(
    // clock and reset
    input wire logic             ref_clk,
    input wire logic             reset,
    // watched ports
    input wire logic             osc_fixed_opt,
    input wire logic             mode_wr,
    input wire logic             mode_bit_op,
    input wire logic [7:0]       mode_rdata,
    input wire logic             bus_wait,
    input wire logic             key_wr,
    input wire logic [7:0]       key_wdata,
    input wire logic [7:0]       key_rdata,
    input wire logic             src_clk_run,
    input wire logic             cpu_halt,
    input wire logic [CNT_W-1:0] wdg_count,
    input wire logic             internal_reset
);
    logic wr_seen;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // ========================================
    // helper: a byte write has been taken
    always_ff @(posedge ref_clk) begin
        if (reset)
            wr_seen <= 1'b0;
        else if (mode_wr && !mode_bit_op)
            wr_seen <= 1'b1;
    end
    // ========================================
    // assertions
    chk_wait_write: assert property (
        mode_wr && !$past(mode_wr) |-> bus_wait ##1 bus_wait ##1 !bus_wait)
        else $error("no wait during mode write");
    chk_wait_idle: assert property (!mode_wr |-> !bus_wait)
        else $error("wait without mode write");
    chk_key_value: assert property (key_rdata == KEY_READBACK)
        else $error("key readback wrong");
    chk_fixed_pat: assert property (
        osc_fixed_opt |-> mode_rdata[7:5] == MODE_FIXED_PAT)
        else $error("fixed pattern lost");
    chk_bad_key: assert property (
        key_wr && key_wdata != KEY_RESTART ##1 src_clk_run[*3]
        |-> internal_reset) else $error("bad key gave no reset");
    chk_defer_rst: assert property (
        !src_clk_run |=> !$rose(internal_reset))
        else $error("reset while source clock stopped");
    chk_second_wr: assert property (
        $rose(mode_wr) && wr_seen ##1 src_clk_run[*3] |-> internal_reset)
        else $error("second write gave no reset");
    chk_bitop_keep: assert property (
        mode_wr && mode_bit_op && !$past(mode_wr)
        |-> ##3 mode_rdata == $past(mode_rdata, 3))
        else $error("bit op changed mode register");
    chk_halt_pause: assert property (
        (!osc_fixed_opt && cpu_halt && !key_wr)[*4] |-> $stable(wdg_count))
        else $error("count moved during halt");
endmodule : wdg_guard_checker
bind wdg_mode_guard wdg_guard_checker chk_i (.*);
`default_nettype wire

// >>> test/test_watchdog_mode_write_guard.sv
// testbench: watchdog mode guard scenarios
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_mode_write_guard
    import wdg_pkg::*;
;
    logic             ref_clk, reset, osc_fixed_opt, mode_wr, mode_bit_op;
    logic             bus_wait, key_wr, src_clk_run, cpu_halt, cpu_stop;
    logic             wdg_running, internal_reset;
    logic [7:0]       mode_wdata, mode_rdata, key_wdata, key_rdata, d, k;
    logic [CNT_W-1:0] wdg_count, cnt_keep;
    int               n_fail = 0, n_tests = 0, cyc = 0;
    wdg_mode_guard uut (.*);
    always #5 ref_clk = ~ref_clk;
    // ========================================
    // tasks
    task automatic chk(string what, logic [19:0] e, logic [19:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", what, e, g);
        end
    endtask : chk
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    function automatic logic [7:0] exp_mode(logic [7:0] v, logic fx);
        return fx ? {MODE_FIXED_PAT, 1'b0, v[3:0]} : v;
    endfunction : exp_mode
    task automatic restart(logic fx);
        reset = 1'b1;
        osc_fixed_opt = fx;
        repeat (12) @(negedge ref_clk);
        reset = 1'b0;
    endtask : restart
    // mode writes only while the main clock runs
    task automatic mwr(logic [7:0] v, logic bop);
        mode_wr = 1'b1;
        mode_wdata = v;
        mode_bit_op = bop;
        #1 chk("bus_wait c0", 1, bus_wait);
        @(negedge ref_clk) chk("bus_wait c1", 1, bus_wait);
        @(negedge ref_clk) chk("bus_wait c2", 0, bus_wait);
        @(negedge ref_clk) mode_wr = 1'b0;
        mode_bit_op = 1'b0;
        @(negedge ref_clk);
    endtask : mwr
    task automatic kwr(logic [7:0] v);
        key_wr = 1'b1;
        key_wdata = v;
        @(negedge ref_clk) key_wr = 1'b0;
    endtask : kwr
    // any reset pulse within n cycles
    task automatic wrst(int n, logic e);
        logic seen;
        seen = 1'b0;
        repeat (n) @(negedge ref_clk) seen = seen | internal_reset;
        chk("internal_reset", e, seen);
    endtask : wrst
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    // ========================================
    // main sequence
    initial begin
        {ref_clk, mode_wr, mode_bit_op, key_wr, cpu_halt, cpu_stop} = '0;
        {mode_wdata, key_wdata} = '0;
        src_clk_run = 1'b1;
        void'($urandom(32'hd580ed4c));
        restart(1'b0);
        chk("mode reset", MODE_RESET, mode_rdata);
        d = {3'h3, 1'b0, 1'($urandom), 3'($urandom_range(7, 3))};
        k = $urandom;
        if (k == KEY_RESTART) k = 8'h00;
        mwr(~d, 1'b1);
        wrst(4, 1'b0);
        chk("mode after bit op", MODE_RESET, mode_rdata);
        mwr(d, 1'b0);
        chk("mode stored", exp_mode(d, 1'b0), mode_rdata);
        kwr(KEY_RESTART);
        wrst(6, 1'b0);
        kwr(k);
        wrst(6, 1'b1);
        chk("key read", KEY_READBACK, key_rdata);
        $display("test 1 done");
        restart(1'b0);
        mwr(d, 1'b0);
        mwr(d, 1'b0);
        wrst(6, 1'b1);
        $display("test 2 done");
        restart(1'b0);
        mwr(d, 1'b0);
        src_clk_run = 1'b0;
        kwr(k);
        wrst(8, 1'b0);
        src_clk_run = 1'b1;
        wrst(4, 1'b1);
        $display("test 3 done");
        restart(1'b1);
        d = {3'($urandom), 1'b1, 1'($urandom), 3'($urandom_range(7, 3))};
        mwr(d, 1'b0);
        chk("fixed pattern", exp_mode(d, 1'b1), mode_rdata);
        restart(1'b1);
        cpu_stop = 1'b1;
        mwr(8'h60, 1'b0);
        wrst(1100, 1'b1);
        cpu_stop = 1'b0;
        $display("test 4 done");
        restart(1'b0);
        mwr(8'h70, 1'b0);
        wrst(1100, 1'b0);
        chk("running", 0, wdg_running);
        $display("test 5 done");
        restart(1'b0);
        mwr(8'h60, 1'b0);
        repeat (3) begin
            wrst(700, 1'b0);
            kwr(KEY_RESTART);
        end
        wrst(600, 1'b0);
        cnt_keep = wdg_count;
        cpu_halt = 1'b1;
        wrst(1100, 1'b0);
        {cpu_halt, cpu_stop} = 2'b01;
        wrst(1100, 1'b0);
        cpu_stop = 1'b0;
        chk("count held", cnt_keep, wdg_count);
        wrst(1100, 1'b1);
        $display("test 6 done");
        give_verdict();
    end
endmodule : test_watchdog_mode_write_guard
`default_nettype wire
